// ==== bench/pcm_pad_model.sv ====
// Board-side load on the port pads: pull-ups and external drivers
`timescale 1ns/1ps
`default_nettype none

module pcm_pad_model
(
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] ext_oe,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pad_in
);
  // ------------------------------------------------------------------
  // Pad resolution
  // ------------------------------------------------------------------
  // Pull-up on every pad, so a released open-drain pin reads high;
  // two drivers that disagree give X rather than a lucky value
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (pad_oe[i] && ext_oe[i])
        pad_in[i] = (pad_out[i] == ext_val[i]) ? ext_val[i] : 1'bx;
      else if (pad_oe[i])
        pad_in[i] = pad_out[i];
      else if (ext_oe[i])
        pad_in[i] = ext_val[i];
      else
        pad_in[i] = 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== bench/pcm_port_mux_tb.sv ====
// Self-checking bench for register access and pin steering of the mux
`timescale 1ns/1ps
`default_nettype none

module pcm_port_mux_tb;
  logic                     clk;
  logic                     rst_b;
  pcm_pkg::pcm_avs_req_t    req;
  pcm_pkg::pcm_periph_out_t po;
  pcm_pkg::pcm_periph_in_t  pi;
  logic                     map_bit;
  logic [7:0]               seg_lvl;
  logic [7:0]               ext_oe;
  logic [7:0]               ext_val;
  logic [7:0]               pad_in;
  logic [7:0]               pad_out;
  logic [7:0]               pad_oe;
  logic [31:0]              rdata_big;
  logic [31:0]              rdata_small;
  logic                     wait_big;
  logic                     wait_small;
  logic                     small_sel;
  logic [7:0]               rd;
  logic [5:0]               seg_ofs [4];
  int                       seg_bit [4];
  int                       failures;
  int                       n_tests;
  int                       cycles = 0;

  pcm_port_mux uut
  (
    .clk(clk), .rst_b(rst_b), .avs_req(req), .avs_readdata(rdata_big),
    .avs_waitrequest(wait_big), .capture_compare_two_map_bit(map_bit),
    .periph_out(po), .periph_in(pi), .seg_level(seg_lvl),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe)
  );

  // Small-package twin shares the bus; only its answers are selected
  pcm_port_mux #(.SMALL_PKG(1'b1)) uut_small
  (
    .clk(clk), .rst_b(rst_b), .avs_req(req), .avs_readdata(rdata_small),
    .avs_waitrequest(wait_small), .capture_compare_two_map_bit(map_bit),
    .periph_out(po), .periph_in(), .seg_level(seg_lvl),
    .pad_in(pad_in), .pad_out(), .pad_oe()
  );

  pcm_pad_model board
  (
    .pad_out(pad_out), .pad_oe(pad_oe), .ext_oe(ext_oe),
    .ext_val(ext_val), .pad_in(pad_in)
  );

  // ------------------------------------------------------------------
  // Clock, timeout and verdict
  // ------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 3000)
    begin
      failures++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // ------------------------------------------------------------------
  // Bus and pin access
  // ------------------------------------------------------------------
  // Waitrequest and read data are taken at the rising edge itself;
  // one idle edge after release keeps drives apart
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [7:0] d, input logic be);
    logic w;
    req.read       <= ~wr;
    req.write      <= wr;
    req.address    <= a;
    req.writedata  <= {24'h0, d};
    req.byteenable <= {3'h0, be};
    do
    begin
      @(posedge clk);
      w  = small_sel ? wait_small : wait_big;
      rd = small_sel ? rdata_small[7:0] : rdata_big[7:0];
    end
    while (w !== 1'b0);
    req.read  <= 1'b0;
    req.write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 1'b1);
  endtask

  task automatic rdc(input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 1'b1);
    chk("readdata", e, rd);
  endtask

  task automatic pin(input int p, input logic oe, input logic v);
    @(negedge clk);
    chk("pad_oe", {7'h0, oe}, {7'h0, pad_oe[p]});
    if (oe)
      chk("pad_out", {7'h0, v}, {7'h0, pad_out[p]});
    @(posedge clk);
  endtask

  // ------------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------------
  initial
  begin
    logic [7:0] rexp [10];
    rexp = '{8'hff, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00,
             8'h00, 8'h00};
    seg_ofs = '{6'h18, 6'h14, 6'h1c, 6'h1c};
    seg_bit = '{0, 4, 3, 4};
    req = '0;
    po = '0;
    map_bit = 1'b0;
    seg_lvl = 8'h5a;
    ext_oe = 8'h00;
    ext_val = 8'h00;
    small_sel = 1'b0;
    failures = 0;
    n_tests = 0;
    rst_b = 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 10; i++)
      rdc(6'(4 * i), rexp[i]);
    chk("pad_oe", 8'h00, pad_oe);
    $display("test reset_values done");

    wr(6'h00, 8'ha5);
    wr(6'h08, 8'h00);
    @(negedge clk);
    chk("pad_oe", 8'hff, pad_oe);
    chk("pad_out", 8'ha5, pad_out);
    @(posedge clk);
    rdc(6'h04, 8'ha5);
    wr(6'h08, 8'hf0);
    ext_oe <= 8'hf0;
    ext_val <= 8'h3c;
    rdc(6'h08, 8'hf0);
    rdc(6'h00, 8'h35);
    @(negedge clk);
    chk("sdi_in", 8'h01, {7'h0, pi.sdi_in});
    chk("ccp1_in", 8'h01, {7'h0, pi.ccp1_in});
    @(posedge clk);
    bus(1'b1, 6'h04, 8'h00, 1'b0);
    rdc(6'h04, 8'ha5);
    ext_oe <= 8'h00;
    $display("test plain_io done");

    wr(6'h04, 8'hff);
    wr(6'h08, 8'h00);
    po.ssu_i2c_mode <= 1'b1;
    pin(4, 1'b1, 1'b0);
    chk("i2c_buf_sel", 8'h01, {7'h0, pi.i2c_buf_sel});
    po.sda_out <= 1'b1;
    pin(4, 1'b0, 1'b0);
    po.ssu_i2c_mode <= 1'b0;
    po.ssu_spi_en <= 1'b1;
    pin(5, 1'b1, 1'b0);
    wr(6'h08, 8'h20);
    pin(5, 1'b0, 1'b0);
    wr(6'h08, 8'h00);
    wr(6'h10, 8'h80);
    po.sdo_out <= 1'b1;
    pin(5, 1'b0, 1'b0);
    po.sdo_out <= 1'b0;
    pin(5, 1'b1, 1'b0);
    wr(6'h10, 8'h00);
    po.ssu_spi_en <= 1'b0;
    po.usu_en <= 1'b1;
    pin(6, 1'b1, 1'b0);
    po.usu_sync <= 1'b1;
    po.usu_master <= 1'b1;
    po.dt_oe <= 1'b1;
    pin(7, 1'b1, 1'b0);
    wr(6'h0c, 8'h40);
    po.tx_out <= 1'b1;
    pin(6, 1'b0, 1'b0);
    pin(7, 1'b1, 1'b0);
    wr(6'h0c, 8'h00);
    $display("test peripheral_override done");

    po.usu_master <= 1'b0;
    po.dt_oe <= 1'b0;
    wr(6'h08, 8'hc0);
    ext_oe <= 8'hc0;
    ext_val <= 8'h40;
    @(negedge clk);
    chk("usu_ck_in", 8'h01, {7'h0, pi.usu_ck_in});
    chk("usu_rx_in", 8'h00, {7'h0, pi.usu_rx_in});
    @(posedge clk);
    ext_oe <= 8'h00;
    wr(6'h08, 8'h00);
    @(negedge clk);
    chk("usu_ck_in", 8'h00, {7'h0, pi.usu_ck_in});
    @(posedge clk);
    po.usu_en <= 1'b0;
    map_bit <= 1'b1;
    po.second_capture_compare_en <= 1'b1;
    pin(1, 1'b1, 1'b0);
    wr(6'h10, 8'h40);
    po.second_capture_compare_out <= 1'b1;
    pin(1, 1'b0, 1'b0);
    map_bit <= 1'b0;
    pin(1, 1'b1, 1'b1);
    wr(6'h10, 8'h00);
    $display("test serial_and_capture done");

    po.ssu_i2c_mode <= 1'b1;
    po.sda_out <= 1'b0;
    po.usu_en <= 1'b1;
    po.usu_sync <= 1'b0;
    po.tx_out <= 1'b0;
    for (int p = 4; p < 8; p++)
    begin
      wr(6'h08, 8'hff);
      wr(seg_ofs[p - 4], 8'(1 << seg_bit[p - 4]));
      pin(p, 1'b1, seg_lvl[p]);
      wr(6'h08, 8'h00);
      pin(p, 1'b1, seg_lvl[p]);
      rdc(seg_ofs[p - 4], 8'(1 << seg_bit[p - 4]));
      bus(1'b0, 6'h00, 8'h00, 1'b1);
      chk("seg_pin_read", 8'h00, {7'h0, rd[p]});
      wr(seg_ofs[p - 4], 8'h00);
    end
    $display("test segments done");

    wr(6'h20, 8'hff);
    small_sel <= 1'b1;
    rdc(6'h20, pcm_pkg::SE4_SMALL_MASK);
    small_sel <= 1'b0;
    rdc(6'h20, 8'hff);
    $display("test small_package done");

    po <= '0;
    rst_b <= 1'b0;
    @(negedge clk);
    chk("pad_oe", 8'h00, pad_oe);
    @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdc(6'h08, 8'hff);
    rdc(6'h20, 8'h00);
    $display("test mid_run_reset done");
    close_out();
  end
endmodule
`default_nettype wire

// ==== core/pcm_pin_cell.sv ====
// One port pin: segment, peripheral and latch priority with open-drain
`timescale 1ns/1ps
`default_nettype none

module pcm_pin_cell
(
  input  wire logic seg_en,
  input  wire logic seg_level,
  input  wire logic fn_drive,
  input  wire logic fn_out,
  input  wire logic fn_od,
  input  wire logic lat,
  input  wire logic dir_in,
  input  wire logic pad_in,
  output logic      pad_out,
  output logic      pad_oe,
  output logic      pin_in
);

  always_comb
  begin
    pin_in = pad_in;
    if (seg_en)
    begin
      // Segment owns the pin; digital input path is cut off
      pad_out = seg_level;
      pad_oe  = 1'b1;
      pin_in  = 1'b0;
    end
    else if (fn_drive)
    begin
      // Open drain only ever pulls low, otherwise lets the pin float
      pad_out = fn_od ? 1'b0 : fn_out;
      pad_oe  = fn_od ? ~fn_out : 1'b1;
    end
    else
    begin
      pad_out = lat;
      pad_oe  = ~dir_in;
    end
  end

endmodule

`default_nettype wire

// ==== core/pcm_pkg.sv ====
// Shared constants and carrier types for the port C upper pin multiplexer
package pcm_pkg;

  // ------------------------------------------------------------------
  // Register map (byte addresses, one aligned word per register)
  // ------------------------------------------------------------------
  localparam int         ADDR_W             = 6;
  localparam logic [5:0] OFS_PIN_LEVELS     = 6'h00;
  localparam logic [5:0] OFS_OUTPUT_LATCH   = 6'h04;
  localparam logic [5:0] OFS_DIRECTION      = 6'h08;
  localparam logic [5:0] OFS_G_LATCH_OD     = 6'h0c;
  localparam logic [5:0] OFS_G_DIR_OD       = 6'h10;
  localparam logic [5:0] OFS_SEG_EN_8_15    = 6'h14;
  localparam logic [5:0] OFS_SEG_EN_16_23   = 6'h18;
  localparam logic [5:0] OFS_SEG_EN_24_31   = 6'h1c;
  localparam logic [5:0] OFS_SEG_EN_32_39   = 6'h20;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] LATCH_RST          = 8'h00;
  localparam logic [7:0] DIR_RST            = 8'hff;
  localparam logic [7:0] G_LATCH_RST        = 8'h00;
  localparam logic [7:0] G_DIR_RST          = 8'hff;
  localparam logic [7:0] SEG_EN_RST         = 8'h00;
  localparam logic [7:0] PINS_RST           = 8'h00;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  // port_g_latch_open_drain
  localparam int         SERIAL_TWO_OD_BIT  = 7;
  localparam int         SERIAL_ONE_OD_BIT  = 6;
  localparam logic [7:0] G_LATCH_MASK       = 8'hdf;
  // port_g_direction_open_drain
  localparam int         SPI_OD_BIT         = 7;
  localparam int         CAPCOMP_TWO_OD_BIT = 6;
  localparam int         CAPCOMP_ONE_OD_BIT = 5;
  // Segment enables feeding port C pins
  localparam int         SEG32_BIT          = 0;
  localparam int         SEG13_BIT          = 5;
  localparam int         SEG17_BIT          = 1;
  localparam int         SEGMENT_SIXTEEN_OUT_BIT          = 0;
  localparam int         SEGMENT_TWELVE_OUT_BIT          = 4;
  localparam int         SEGMENT_TWENTY_SEVEN_OUT_BIT          = 3;
  localparam int         SEGMENT_TWENTY_EIGHT_OUT_BIT          = 4;
  // Only segment 32 exists in the fourth enable register on small parts
  localparam logic [7:0] SE4_SMALL_MASK     = 8'h01;

  // ------------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [31:0]       writedata;
    logic [3:0]        byteenable;
  } pcm_avs_req_t;

  // Peripheral outputs and modes that steer the pins
  typedef struct packed {
    logic ssu_i2c_mode;
    logic ssu_spi_en;
    logic sda_out;
    logic sdo_out;
    logic usu_en;
    logic usu_sync;
    logic usu_master;
    logic tx_out;
    logic dt_out;
    logic dt_oe;
    logic ccp1_en;
    logic ccp1_out;
    logic second_capture_compare_en;
    logic second_capture_compare_out;
  } pcm_periph_out_t;

  // Pin levels delivered back to the peripherals
  typedef struct packed {
    logic sdi_in;
    logic i2c_buf_sel;
    logic usu_ck_in;
    logic usu_rx_in;
    logic ccp1_in;
    logic second_capture_compare_in;
  } pcm_periph_in_t;

endpackage

// ==== core/pcm_port_mux.sv ====
// Port C pin multiplexer with its register file on an Avalon-MM slave
`timescale 1ns/1ps
`default_nettype none

module pcm_port_mux
#(
  parameter bit SMALL_PKG = 1'b0
)
(
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire pcm_pkg::pcm_avs_req_t   avs_req,
  output logic [31:0]                  avs_readdata,
  output logic                         avs_waitrequest,
  input  wire logic                    capture_compare_two_map_bit,
  input  wire pcm_pkg::pcm_periph_out_t periph_out,
  output pcm_pkg::pcm_periph_in_t      periph_in,
  input  wire logic [7:0]              seg_level,
  input  wire logic [7:0]              pad_in,
  output logic [7:0]                   pad_out,
  output logic [7:0]                   pad_oe
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  lat;
    logic [7:0]  dir;
    logic [7:0]  glat;
    logic [7:0]  gdir;
    logic [7:0]  se1;
    logic [7:0]  se2;
    logic [7:0]  se3;
    logic [7:0]  se4;
    logic [7:0]  pins;
    logic [31:0] rdata;
    logic        ack;
  } pcm_state_t;

  localparam pcm_state_t STATE_RST = '{
    lat:   pcm_pkg::LATCH_RST,
    dir:   pcm_pkg::DIR_RST,
    glat:  pcm_pkg::G_LATCH_RST,
    gdir:  pcm_pkg::G_DIR_RST,
    se1:   pcm_pkg::SEG_EN_RST,
    se2:   pcm_pkg::SEG_EN_RST,
    se3:   pcm_pkg::SEG_EN_RST,
    se4:   pcm_pkg::SEG_EN_RST,
    pins:  pcm_pkg::PINS_RST,
    rdata: 32'h0000_0000,
    ack:   1'b0
  };

  pcm_state_t st_r;
  pcm_state_t st_nxt;

  logic [7:0] seg_en;
  logic [7:0] fn_drive;
  logic [7:0] fn_out;
  logic [7:0] fn_od;
  logic [7:0] pin_in;
  logic       req;
  logic       wr_take;

  // ------------------------------------------------------------------
  // Register read decode
  // ------------------------------------------------------------------
  function automatic logic [7:0] reg_read(
    input logic [pcm_pkg::ADDR_W-1:0] addr,
    input pcm_state_t                 s
  );
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      pcm_pkg::OFS_PIN_LEVELS:   v = s.pins;
      pcm_pkg::OFS_OUTPUT_LATCH: v = s.lat;
      pcm_pkg::OFS_DIRECTION:    v = s.dir;
      pcm_pkg::OFS_G_LATCH_OD:   v = s.glat & pcm_pkg::G_LATCH_MASK;
      pcm_pkg::OFS_G_DIR_OD:     v = s.gdir;
      pcm_pkg::OFS_SEG_EN_8_15:  v = s.se1;
      pcm_pkg::OFS_SEG_EN_16_23: v = s.se2;
      pcm_pkg::OFS_SEG_EN_24_31: v = s.se3;
      pcm_pkg::OFS_SEG_EN_32_39: v = s.se4;
      default:                   v = 8'h00;
    endcase
    return v;
  endfunction

  // ------------------------------------------------------------------
  // Per-pin function selection
  // ------------------------------------------------------------------
  always_comb
  begin
    seg_en    = 8'h00;
    seg_en[1] = st_r.se4[pcm_pkg::SEG32_BIT];
    seg_en[2] = st_r.se1[pcm_pkg::SEG13_BIT];
    seg_en[3] = st_r.se2[pcm_pkg::SEG17_BIT];
    seg_en[4] = st_r.se2[pcm_pkg::SEGMENT_SIXTEEN_OUT_BIT];
    seg_en[5] = st_r.se1[pcm_pkg::SEGMENT_TWELVE_OUT_BIT];
    seg_en[6] = st_r.se3[pcm_pkg::SEGMENT_TWENTY_SEVEN_OUT_BIT];
    seg_en[7] = st_r.se3[pcm_pkg::SEGMENT_TWENTY_EIGHT_OUT_BIT];

    fn_drive = 8'h00;
    fn_out   = 8'h00;
    fn_od    = 8'h00;
    // Capture/compare two only appears here when the map strap is set
    fn_drive[1] = capture_compare_two_map_bit & periph_out.second_capture_compare_en
                  & ~st_r.dir[1];
    fn_out[1]   = periph_out.second_capture_compare_out;
    fn_od[1]    = st_r.gdir[pcm_pkg::CAPCOMP_TWO_OD_BIT];
    fn_drive[2] = periph_out.ccp1_en & ~st_r.dir[2];
    fn_out[2]   = periph_out.ccp1_out;
    fn_od[2]    = st_r.gdir[pcm_pkg::CAPCOMP_ONE_OD_BIT];
    // I2C data is a wired-AND bus, so it never drives high
    fn_drive[4] = periph_out.ssu_i2c_mode;
    fn_out[4]   = periph_out.sda_out;
    fn_od[4]    = 1'b1;
    fn_drive[5] = periph_out.ssu_spi_en & ~st_r.dir[5];
    fn_out[5]   = periph_out.sdo_out;
    fn_od[5]    = st_r.gdir[pcm_pkg::SPI_OD_BIT];
    // Async transmit and sync master clock force the pin out
    fn_drive[6] = periph_out.usu_en
                  & (~periph_out.usu_sync | periph_out.usu_master);
    fn_out[6]   = periph_out.tx_out;
    fn_od[6]    = st_r.glat[pcm_pkg::SERIAL_ONE_OD_BIT];
    fn_drive[7] = periph_out.usu_en & periph_out.usu_sync
                  & periph_out.dt_oe;
    fn_out[7]   = periph_out.dt_out;
    fn_od[7]    = st_r.glat[pcm_pkg::SERIAL_ONE_OD_BIT];
  end

  // ------------------------------------------------------------------
  // Pin cells
  // ------------------------------------------------------------------
  for (genvar i = 0; i < 8; i++)
  begin : g_pin
    pcm_pin_cell u_cell
    (
      .seg_en    (seg_en[i]),
      .seg_level (seg_level[i]),
      .fn_drive  (fn_drive[i]),
      .fn_out    (fn_out[i]),
      .fn_od     (fn_od[i]),
      .lat       (st_r.lat[i]),
      .dir_in    (st_r.dir[i]),
      .pad_in    (pad_in[i]),
      .pad_out   (pad_out[i]),
      .pad_oe    (pad_oe[i]),
      .pin_in    (pin_in[i])
    );
  end

  // ------------------------------------------------------------------
  // Inputs back to the peripherals
  // ------------------------------------------------------------------
  always_comb
  begin
    periph_in.sdi_in      = pin_in[4];
    periph_in.i2c_buf_sel = periph_out.ssu_i2c_mode;
    // Slave clock needs the pin left as input by software
    periph_in.usu_ck_in   = periph_out.usu_sync & ~periph_out.usu_master
                            & st_r.dir[6] & pin_in[6];
    // Receive line idles high when the pin is not an input
    periph_in.usu_rx_in   = st_r.dir[7] ? pin_in[7] : 1'b1;
    periph_in.ccp1_in     = pin_in[2];
    periph_in.second_capture_compare_in     = capture_compare_two_map_bit & pin_in[1];
  end

  // ------------------------------------------------------------------
  // Bus slave and register file
  // ------------------------------------------------------------------
  // One wait state on every access; the write lands on the release edge
  assign req             = avs_req.read | avs_req.write;
  assign avs_waitrequest = req & ~st_r.ack;
  assign avs_readdata    = st_r.rdata;
  assign wr_take         = avs_req.write & st_r.ack & avs_req.byteenable[0];

  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.pins = pin_in;
    st_nxt.ack  = 1'b0;
    if (req && !st_r.ack)
    begin
      st_nxt.ack   = 1'b1;
      st_nxt.rdata = {24'h00_0000, reg_read(avs_req.address, st_r)};
    end
    if (wr_take)
    begin
      case (avs_req.address)
        // Writing the pin register lands in the output latch
        pcm_pkg::OFS_PIN_LEVELS:   st_nxt.lat  = avs_req.writedata[7:0];
        pcm_pkg::OFS_OUTPUT_LATCH: st_nxt.lat  = avs_req.writedata[7:0];
        pcm_pkg::OFS_DIRECTION:    st_nxt.dir  = avs_req.writedata[7:0];
        pcm_pkg::OFS_G_LATCH_OD:   st_nxt.glat = avs_req.writedata[7:0]
                                                 & pcm_pkg::G_LATCH_MASK;
        pcm_pkg::OFS_G_DIR_OD:     st_nxt.gdir = avs_req.writedata[7:0];
        pcm_pkg::OFS_SEG_EN_8_15:  st_nxt.se1  = avs_req.writedata[7:0];
        pcm_pkg::OFS_SEG_EN_16_23: st_nxt.se2  = avs_req.writedata[7:0];
        pcm_pkg::OFS_SEG_EN_24_31: st_nxt.se3  = avs_req.writedata[7:0];
        pcm_pkg::OFS_SEG_EN_32_39: st_nxt.se4  = SMALL_PKG
          ? (avs_req.writedata[7:0] & pcm_pkg::SE4_SMALL_MASK)
          : avs_req.writedata[7:0];
        default:                   st_nxt.se4  = st_r.se4;
      endcase
    end
  end

  // Reset sets every direction bit to input and every segment enable off
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st_r <= STATE_RST;
    else
      st_r <= st_nxt;
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  segment_sixteen_out_owns_a: assert property (seg_en[4] |-> pad_oe[4]
      && pad_out[4] == seg_level[4] && pin_in[4] == 1'b0)
    else $error("segment 16 does not own pin 4");

  segment_twelve_out_owns_a: assert property (seg_en[5]
      |-> pad_oe[5] && pad_out[5] == seg_level[5])
    else $error("segment 12 does not own pin 5");

  segment_twenty_seven_out_owns_a: assert property (seg_en[6]
      |-> pad_oe[6] && pad_out[6] == seg_level[6])
    else $error("segment 27 does not own pin 6");

  segment_twenty_eight_out_owns_a: assert property (seg_en[7] && periph_out.usu_en
      |-> pad_out[7] == seg_level[7] && pad_oe[7])
    else $error("segment 28 lost pin 7 to a peripheral");

  i2c_data_drive_a: assert property (!seg_en[4]
      && periph_out.ssu_i2c_mode
      |-> pad_oe[4] == !periph_out.sda_out && pad_out[4] == 1'b0)
    else $error("I2C data does not drive pin 4");

  i2c_buffer_sel_a: assert property (periph_out.ssu_i2c_mode
      |-> periph_in.i2c_buf_sel)
    else $error("I2C buffer not selected on pin 4");

  sdo_needs_out_a: assert property (!seg_en[5] && st_r.dir[5]
      |-> !pad_oe[5])
    else $error("SPI data driven while pin 5 is input");

  tx_override_a: assert property (!seg_en[6] && periph_out.usu_en
      && !periph_out.usu_sync && !fn_od[6]
      |-> pad_oe[6] && pad_out[6] == periph_out.tx_out)
    else $error("transmit does not override latch on pin 6");

  ck_slave_in_a: assert property (!seg_en[6] && periph_out.usu_sync
      && !periph_out.usu_master && st_r.dir[6]
      |-> periph_in.usu_ck_in == pad_in[6] && !pad_oe[6])
    else $error("slave clock not taken from pin 6");

  rx_in_a: assert property (!seg_en[7] && st_r.dir[7]
      |-> periph_in.usu_rx_in == pad_in[7])
    else $error("receive data not taken from pin 7");

  second_capture_compare_map_a: assert property (!capture_compare_two_map_bit
      |-> !fn_drive[1])
    else $error("capture/compare two on pin 1 while unmapped");

  se4_small_a: assert property (SMALL_PKG
      |-> st_r.se4[7:1] == 7'h00)
    else $error("unimplemented segment enables set");

  reset_inputs_a: assert property ($rose(rst_b)
      |-> st_r.dir == pcm_pkg::DIR_RST && seg_en == 8'h00)
    else $error("pins not inputs after reset");

  dir_readback_a: assert property (avs_req.read && !st_r.ack
      && avs_req.address == pcm_pkg::OFS_DIRECTION
      |=> avs_readdata[7:0] == $past(st_r.dir) && !avs_waitrequest)
    else $error("direction readback wrong");

  latch_write_a: assert property (wr_take
      && avs_req.address == pcm_pkg::OFS_PIN_LEVELS
      |=> st_r.lat == $past(avs_req.writedata[7:0]))
    else $error("pin register write missed the latch");

  latch_path_a: assert property (seg_en == 8'h00 && fn_drive == 8'h00
      |-> pad_oe == ~st_r.dir && pad_out == st_r.lat)
    else $error("latch path wrong with no overrides");

  bus_answer_a: assert property (req && !st_r.ack |=> !avs_waitrequest)
    else $error("bus answer late");

  seg_pin4_c: cover property (seg_en[4] && periph_out.ssu_i2c_mode);
  spi_out_c:  cover property (fn_drive[5] && !seg_en[5]);
  slave_ck_c: cover property (periph_out.usu_sync && st_r.dir[6]);
  wr_take_c:  cover property (wr_take);

endmodule

`default_nettype wire
